// >>> dac_load_defs.svh
/*
 constants shared by both ends of the serial converter load link.
 assumes the includer wants text macros only; no logic here.
*/
// Behaviour
// - capture data on serial clock rising edges
// - sixteen bit words, most significant first
// - select rise with load low updates output
// - select rise with load high preloads only
// - load strobe low transfers input register
// - ignore clock and data while deselected
// - input register separate from converter register
// - serial clock no faster than 50 MHz
// - converter register zero at power up
// - top nibble thermometer, low twelve binary
// - code is straight unsigned binary
// - clear zeroes both, blocks load strobes
// - keep last sixteen bits shifted in
// - power up leaves input register uncleared
`ifndef DAC_LOAD_DEFS_SVH
`define DAC_LOAD_DEFS_SVH
`define DAC_WORD_BITS     16
`define DAC_SEG_BITS      4
`define DAC_SEG_COUNT     15
`define DAC_LADDER_BITS   12
`define DAC_CODE_ZERO     16'h0000
`define DAC_SCLK_MAX_MHZ  50
`define DAC_CLK_MHZ       250
// half period of the made serial clock, in system cycles; rounds up
`define DAC_SCLK_HALF     ((`DAC_CLK_MHZ + 2 * `DAC_SCLK_MAX_MHZ - 1) / (2 * `DAC_SCLK_MAX_MHZ))
`endif

// >>> dac_load_pkg.sv
/*
 types for the serial converter load link.
 assumes dac_load_defs.svh is on the include path.
*/
`include "dac_load_defs.svh"
package dac_load_pkg;
    typedef logic [`DAC_WORD_BITS-1:0] dac_word_t;
    typedef enum logic [1:0] {
        host_idle,
        host_shift,
        host_close,
        host_strobe
    } host_state_e;
endpackage : dac_load_pkg

// >>> dac_link_if.sv
/*
 pins between the serial controller and the converter front end.
 assumes both ends share nothing but these wires.
*/
interface dac_link_if;
    logic sclk;
    logic sdata;
    logic frame_select_n;
    logic load_output_n;
    logic clear_n;
    modport host (output sclk, output sdata, output frame_select_n,
                  output load_output_n, output clear_n);
    modport device (input sclk, input sdata, input frame_select_n,
                    input load_output_n, input clear_n);
endinterface : dac_link_if

// >>> dac_load_device.sv
/*
 converter front end: input shift register, converter register, switch decode.
 assumes link pins are asynchronous to clk; each is synchronised by two flops.
*/
`include "dac_load_defs.svh"
module dac_load_device
    import dac_load_pkg::*;
(
    input  wire logic                        clk,        // system clock
    input  wire logic                        rstn,       // power-on reset, sync low
    dac_link_if.device                       link,       // serial pins
    output      dac_word_t                   dac_code,   // converter register
    output      logic [`DAC_SEG_COUNT-1:0]   seg_sw,     // thermometer segments
    output      logic [`DAC_LADDER_BITS-1:0] ladder_sw   // binary ladder switches
);
    // bit order of the pin bank; the reset image below follows it
    localparam int                   PIN_SCLK  = 0;
    localparam int                   PIN_DATA  = 1;
    localparam int                   PIN_CS    = 2;
    localparam int                   PIN_LD    = 3;
    localparam int                   PIN_CLR   = 4;
    localparam int                   PIN_COUNT = 5;
    // idle pin levels, so that no false edge follows reset
    localparam logic [PIN_COUNT-1:0] PIN_IDLE  = 5'h1c;

    logic [PIN_COUNT-1:0]      pin_raw;
    logic [PIN_COUNT-1:0]      pin_meta;
    logic [PIN_COUNT-1:0]      pin_sync;
    logic [PIN_COUNT-1:0]      pin_last;
    logic                      sel_low;
    logic                      load_low;
    logic                      clear_low;
    logic                      sclk_rise;
    logic                      cs_rise;
    logic                      ld_fall;
    logic                      clr_fall;
    logic                      shift_en;
    logic                      load_req;
    dac_word_t                 shift_reg;
    dac_word_t                 next_shift;
    logic [`DAC_SEG_BITS-1:0]  top_nibble;
    logic [`DAC_SEG_COUNT-1:0] next_seg;

    assign pin_raw = {link.clear_n,
                      link.load_output_n,
                      link.frame_select_n,
                      link.sdata,
                      link.sclk};

    // two flops per pin; only the second one is read by logic
    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    pin_meta[p] <= PIN_IDLE[p];
                    pin_sync[p] <= PIN_IDLE[p];
                end else begin
                    pin_meta[p] <= pin_raw[p];
                    pin_sync[p] <= pin_meta[p];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pin_last <= PIN_IDLE;
        end else begin
            pin_last <= pin_sync;
        end
    end

    assign sel_low   = ~pin_sync[PIN_CS];
    assign load_low  = ~pin_sync[PIN_LD];
    assign clear_low = ~pin_sync[PIN_CLR];
    assign sclk_rise = pin_sync[PIN_SCLK] & ~pin_last[PIN_SCLK];
    assign cs_rise   = pin_sync[PIN_CS] & ~pin_last[PIN_CS];
    assign ld_fall   = ~pin_sync[PIN_LD] & pin_last[PIN_LD];
    // clear acts on its falling edge; held low it only masks the strobe
    assign clr_fall  = ~pin_sync[PIN_CLR] & pin_last[PIN_CLR];
    assign shift_en  = sclk_rise & sel_low;
    // edge-driven so a load held low does not leak half-shifted words
    assign load_req  = (cs_rise & load_low) | ld_fall;

    always_comb begin
        next_shift = {shift_reg[`DAC_WORD_BITS-2:0], pin_sync[PIN_DATA]};
    end

    // no reset on purpose: contents undefined until loaded
    always_ff @(posedge clk) begin
        if (clr_fall) begin
            shift_reg <= `DAC_CODE_ZERO;
        end else if (shift_en) begin
            shift_reg <= next_shift;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dac_code <= `DAC_CODE_ZERO;
        end else if (clr_fall) begin
            dac_code <= `DAC_CODE_ZERO;
        end else if (load_req && !clear_low) begin
            dac_code <= shift_reg;
        end
    end

    // segment k on when top nibble exceeds k; unsigned code throughout
    assign top_nibble = dac_code[`DAC_WORD_BITS-1 -: `DAC_SEG_BITS];

    genvar k;
    generate
        for (k = 0; k < `DAC_SEG_COUNT; k++) begin : g_seg
            assign next_seg[k] = (top_nibble > 4'(k));
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rstn) begin
            seg_sw <= '0;
        end else begin
            seg_sw <= next_seg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ladder_sw <= '0;
        end else begin
            ladder_sw <= dac_code[`DAC_LADDER_BITS-1:0];
        end
    end
endmodule : dac_load_device

// >>> dac_load_host.sv
/*
 serial controller end: shifts one word out, then optionally strobes load.
 assumes the device samples on rising serial clock edges.
*/
`include "dac_load_defs.svh"
module dac_load_host
    import dac_load_pkg::*;
(
    input  wire logic  clk,        // system clock
    input  wire logic  rstn,       // sync reset, active low
    input  wire logic  req_valid,  // start a word
    input  wire dac_word_t req_word, // word to send
    input  wire logic  req_load,   // strobe load after the frame
    input  wire logic  req_clear,  // pulse clear low
    output      logic  req_ready,  // idle, may accept
    dac_link_if.host   link        // serial pins
);
    host_state_e state;
    dac_word_t   word;
    logic        load_pend;
    logic [4:0]  bit_cnt;
    logic [7:0]  div_cnt;
    logic        clr_hold;

    assign req_ready = (state == host_idle) && !clr_hold;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state               <= host_idle;
            word                <= `DAC_CODE_ZERO;
            load_pend           <= 1'b0;
            bit_cnt             <= 5'h0;
            div_cnt             <= 8'h0;
            link.sclk           <= 1'b0;
            link.sdata          <= 1'b0;
            link.frame_select_n <= 1'b1;
            link.load_output_n  <= 1'b1;
        end else begin
            case (state)
                host_idle: begin
                    if (req_valid && !clr_hold) begin
                        word                <= req_word;
                        load_pend           <= req_load;
                        bit_cnt             <= 5'h0;
                        div_cnt             <= 8'h0;
                        link.frame_select_n <= 1'b0;
                        link.sdata          <= req_word[`DAC_WORD_BITS-1];
                        state               <= host_shift;
                    end
                end
                host_shift: begin
                    // divider keeps serial clock at or below its limit
                    if (div_cnt == 8'(`DAC_SCLK_HALF - 1)) begin
                        div_cnt <= 8'h0;
                        if (!link.sclk) begin
                            link.sclk <= 1'b1;
                        end else begin
                            link.sclk <= 1'b0;
                            word      <= {word[`DAC_WORD_BITS-2:0], 1'b0};
                            link.sdata <= word[`DAC_WORD_BITS-2];
                            bit_cnt   <= bit_cnt + 5'h1;
                            if (bit_cnt == 5'(`DAC_WORD_BITS - 1)) begin
                                state <= host_close;
                            end
                        end
                    end else begin
                        div_cnt <= div_cnt + 8'h1;
                    end
                end
                host_close: begin
                    link.frame_select_n <= 1'b1;
                    div_cnt             <= 8'h0;
                    if (load_pend) begin
                        link.load_output_n <= 1'b0;
                        state              <= host_strobe;
                    end else begin
                        state <= host_idle;
                    end
                end
                host_strobe: begin
                    if (div_cnt == 8'(`DAC_SCLK_HALF * 4)) begin
                        link.load_output_n <= 1'b1;
                        state              <= host_idle;
                    end else begin
                        div_cnt <= div_cnt + 8'h1;
                    end
                end
                default: state <= host_idle;
            endcase
        end
    end

    logic [7:0] clr_cnt;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            clr_hold     <= 1'b0;
            clr_cnt      <= 8'h0;
            link.clear_n <= 1'b1;
        end else if (req_clear && state == host_idle && !clr_hold) begin
            clr_hold     <= 1'b1;
            clr_cnt      <= 8'h0;
            link.clear_n <= 1'b0;
        end else if (clr_hold) begin
            clr_cnt <= clr_cnt + 8'h1;
            if (clr_cnt == 8'(`DAC_SCLK_HALF * 4)) begin
                link.clear_n <= 1'b1;
                clr_hold     <= 1'b0;
            end
        end
    end
endmodule : dac_load_host

// >>> serial_dac_load_checker.sv
/*
 concurrent checks on the serial load link and the converter code.
 assumes link pins and dac_code are wired in by name; one clock domain.
*/
`include "dac_load_defs.svh"
module serial_dac_load_checker
    import dac_load_pkg::*;
(
    input wire logic      clk,             // system clock
    input wire logic      rstn,            // sync reset, low
    input wire logic      sclk,            // serial clock
    input wire logic      sdata,           // serial data
    input wire logic      frame_select_n,  // frame select
    input wire logic      load_output_n,   // load strobe
    input wire logic      clear_n,         // clear
    input wire dac_word_t dac_code         // converter register
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       sclk_q;
    logic [4:0] rises;
    logic [2:0] quiet;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
    end
    // count cleared while deselected, so it holds the frame's rises at select rise
    always_ff @(posedge clk) begin
        if (!rstn || frame_select_n) begin
            rises <= '0;
        end else if (sclk && !sclk_q) begin
            rises <= rises + 5'd1;
        end
    end
    // the synchroniser lag means code may still move a few cycles after a strobe
    always_ff @(posedge clk) begin
        if (!rstn || !load_output_n || !clear_n) begin
            quiet <= '0;
        end else if (quiet != 3'd7) begin
            quiet <= quiet + 3'd1;
        end
    end
    chk_idle_clock: assert property (frame_select_n |-> !sclk)
        else $error("serial clock moved outside a frame");
    chk_clock_rate: assert property ($rose(sclk) |-> sclk[*3] ##1 !sclk)
        else $error("serial clock high phase wrong");
    chk_data_steady: assert property ($rose(sclk) |-> $stable(sdata))
        else $error("data moved at the sampling edge");
    chk_word_length: assert property ($rose(frame_select_n) |-> rises == 5'd16)
        else $error("frame did not carry sixteen bits");
    chk_load_follows: assert property ($fell(load_output_n) |-> frame_select_n)
        else $error("load strobe inside a frame");
    chk_load_width: assert property ($fell(load_output_n) |->
        !load_output_n[*8] ##5 !load_output_n ##1 load_output_n)
        else $error("load strobe width wrong");
    chk_clear_width: assert property ($fell(clear_n) |->
        !clear_n[*8] ##5 !clear_n ##1 clear_n)
        else $error("clear pulse width wrong");
    chk_clear_zero: assert property ($fell(clear_n) |->
        ##[2:6] dac_code == `DAC_CODE_ZERO)
        else $error("clear did not zero the code");
    chk_code_holds: assert property (quiet == 3'd7 |-> $stable(dac_code))
        else $error("code changed without a strobe");
endmodule : serial_dac_load_checker

// >>> test_serial_dac_load_logic.sv
/*
 bench: host end shifts words into the device end across the link.
 assumes package, interface, both ends and the checker are compiled first.
*/
module test_serial_dac_load_logic
    import dac_load_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;
    logic        rstn;
    logic        req_valid;
    dac_word_t   req_word;
    logic        req_load;
    logic        req_clear;
    logic        req_ready;
    dac_word_t   dac_code;
    logic [14:0] seg_sw;
    logic [11:0] ladder_sw;
    int          n_fail;
    int          cmp_count;
    int          cycles;
    dac_link_if link ();
    dac_load_host i_dac_load_host (.clk(clk), .rstn(rstn), .req_valid(req_valid),
        .req_word(req_word), .req_load(req_load), .req_clear(req_clear),
        .req_ready(req_ready), .link(link.host));
    dac_load_device i_dac_load_device (.clk(clk), .rstn(rstn), .link(link.device),
        .dac_code(dac_code), .seg_sw(seg_sw), .ladder_sw(ladder_sw));
    serial_dac_load_checker i_serial_dac_load_checker (.clk(clk), .rstn(rstn),
        .sclk(link.sclk), .sdata(link.sdata), .frame_select_n(link.frame_select_n),
        .load_output_n(link.load_output_n), .clear_n(link.clear_n), .dac_code(dac_code));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input dac_word_t code, input string what);
        logic [15:0] seg;
        seg = (16'h0001 << code[15:12]) - 16'h0001;
        cmp_count++;
        if (dac_code !== code || seg_sw !== seg[14:0] || ladder_sw !== code[11:0]) begin
            n_fail++;
            $display("[FAIL] %0t %s: code %h seg %h", $time, what, dac_code, seg_sw);
        end
        $display("test %s done", what);
    endtask : check
    // ready returns only after any load or clear pulse has ended
    task automatic settle();
        for (int i = 0; i < 400 && req_ready !== 1'b1; i++) @(posedge clk);
        repeat (8) @(posedge clk);
        #1;
    endtask : settle
    task automatic send(input dac_word_t w, input logic ld);
        req_word = w;
        req_load = ld;
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_valid = 1'b0;
        settle();
    endtask : send
    task automatic do_clear();
        req_clear = 1'b1;
        @(posedge clk);
        #1 req_clear = 1'b0;
        settle();
    endtask : do_clear
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_word = 16'h0000;
        req_load = 1'b0;
        req_clear = 1'b0;
        repeat (10) @(posedge clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge clk);
        check(16'h0000, "power up");
        send(16'hA5C3, 1'b1);
        check(16'hA5C3, "load");
        send(16'h1234, 1'b0);
        check(16'hA5C3, "preload");
        do_clear();
        check(16'h0000, "clear");
        // every top nibble, ending on all ones
        for (int k = 0; k < 16; k++) begin
            send({4'(k), {3{4'(k)}}}, 1'b1);
            check({4'(k), {3{4'(k)}}}, "segments");
        end
        wrap_up();
    end
endmodule : test_serial_dac_load_logic
